// ==== bench/snar_host_model.sv ====
// Host and south-neighbour stand-in that presents frames to the register bank.
// Assumes the bench calls one task at a time, after reset has been released.
`timescale 1ns/100ps
module snar_host_model (
    input  wire logic       core_clk,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            cs_in,
    output logic            wr_stb,
    output logic            rd_stb,
    output logic [7:0]      pkt_hdr,
    output logic [7:0]      pkt_reg,
    output logic [7:0]      pkt_data,
    output logic            pkt_crc_ok
);
    initial begin
        cs_in = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        pkt_hdr = 8'h55;
        pkt_reg = 8'haa;
        pkt_data = 8'h55;
        pkt_crc_ok = 1'b0;
    end

    // The select is raised three edges early so the synchroniser sees it.
    task automatic frame_open(input logic [5:0] a, input logic [7:0] rg, input logic [7:0] dat, input logic wr);
        @(negedge core_clk);
        cs_in = 1'b1;
        repeat (3) @(negedge core_clk);
        pkt_hdr = {1'b0, a, wr};
        pkt_reg = rg;
        pkt_data = dat;
    endtask : frame_open

    // Released fields carry inverted junk, so a stale value never looks valid.
    task automatic frame_close();
        @(negedge core_clk);
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        pkt_hdr = ~pkt_hdr;
        pkt_reg = ~pkt_reg;
        pkt_data = ~pkt_data;
        cs_in = 1'b0;
    endtask : frame_close

    task automatic wr(input logic [5:0] a, input logic [7:0] rg, input logic [7:0] dat, input logic ok);
        frame_open(a, rg, dat, 1'b1);
        pkt_crc_ok = ok;
        wr_stb = 1'b1;
        frame_close();
        pkt_crc_ok = ~ok;
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] rg, output logic [7:0] dat, output logic got);
        int n;
        got = 1'b0;
        dat = 8'h00;
        frame_open(a, rg, 8'h00, 1'b0);
        rd_stb = 1'b1;
        for (n = 0; n < 4; n++) begin
            @(negedge core_clk);
            rd_stb = 1'b0;
            if (rd_valid === 1'b1 && got === 1'b0) begin
                got = 1'b1;
                dat = rd_data;
            end
        end
        frame_close();
    endtask : rd
endmodule : snar_host_model

// ==== bench/testbench.sv ====
// Self-checking bench for the stacked node register bank.
// Assumes the host model is the only source of frames and chip select.
`timescale 1ns/100ps
module testbench;
    import snar_pkg::*;
    localparam logic [95:0] BLANK = 96'h0c0b0a09_08070605_04030201;
    localparam logic [5:0]  NA    = 6'h05;
    logic        core_clk;
    logic        reset;
    logic        alert_north_in;
    logic        programming_supply_pins;
    logic        cs_in;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  pkt_hdr;
    logic [7:0]  pkt_reg;
    logic [7:0]  pkt_data;
    logic        pkt_crc_ok;
    logic        cs_north_out;
    logic        alert_south_out;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic [5:0]  node_address;
    logic        otp_burned;
    logic [95:0] prot_config;
    logic [7:0]  d;
    logic        g;
    logic        selected;
    int          sel_count = 0;
    int          failures;
    int          compares;

    snar_regs #(.OTP_BLANK(BLANK)) u_dut (.core_clk(core_clk), .reset(reset), .cs_in(cs_in),
        .alert_north_in(alert_north_in), .programming_supply_pins(programming_supply_pins),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .pkt_hdr(pkt_hdr), .pkt_reg(pkt_reg), .pkt_data(pkt_data),
        .pkt_crc_ok(pkt_crc_ok), .cs_north_out(cs_north_out), .alert_south_out(alert_south_out),
        .selected(selected), .rd_valid(rd_valid), .rd_data(rd_data), .node_address(node_address),
        .otp_burned(otp_burned), .prot_config(prot_config));

    snar_host_model u_host (.core_clk(core_clk), .rd_valid(rd_valid), .rd_data(rd_data), .cs_in(cs_in),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .pkt_hdr(pkt_hdr), .pkt_reg(pkt_reg), .pkt_data(pkt_data),
        .pkt_crc_ok(pkt_crc_ok));

    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] seen);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input string what, input logic [7:0] rg, input logic [7:0] exp);
        u_host.rd(NA, rg, d, g);
        check({what, " answered"}, 1'b1, g);
        check(what, exp, d);
    endtask : rd_chk

    // The select path has a synchroniser in it, so allow a few edges.
    task automatic wait_pins(input logic north, input logic south);
        int n;
        for (n = 0; n < 8 && (cs_north_out !== north || alert_south_out !== south); n++) @(negedge core_clk);
        if (cs_north_out !== north || alert_south_out !== south) begin
            check("pin wait", {north, south}, {cs_north_out, alert_south_out});
            stop_test();
        end
    endtask : wait_pins

    // Select pulses last one cycle, so count them at every falling edge.
    always @(negedge core_clk) begin
        if (selected === 1'b1) begin
            sel_count++;
        end
    end

    task automatic t_reset();
        u_host.cs_in = 1'b1;
        // The select is raised on purpose: address zero must still block it.
        repeat (4) @(negedge core_clk);
        check("node address", 6'h00, node_address);
        check("south alert", 1'b1, alert_south_out);
        check("north select", 1'b0, cs_north_out);
        check("protected image", BLANK, prot_config);
        u_host.cs_in = 1'b0;
    endtask : t_reset

    task automatic t_address();
        u_host.wr(ADDR_NONE, OFS_ADDR_CTRL, NA, 1'b1);
        check("node address", NA, node_address);
        wait_pins(1'b0, 1'b0);
        check("south alert", 1'b0, alert_south_out);
        rd_chk("address control", OFS_ADDR_CTRL, 8'h85);
        u_host.rd(NA, OFS_DEV_STATUS, d, g);
        check("status request flag", 1'b1, d[AR_BIT]);
        u_host.cs_in = 1'b1;
        alert_north_in = 1'b1;
        wait_pins(1'b1, 1'b1);
        check("north select follows", 1'b1, cs_north_out);
        check("north alert passed", 1'b1, alert_south_out);
        u_host.cs_in = 1'b0;
        alert_north_in = 1'b0;
        wait_pins(1'b0, 1'b0);
        check("north select released", 1'b0, cs_north_out);
    endtask : t_address

    task automatic t_range();
        int s;
        s = sel_count;
        u_host.rd(ADDR_NONE, OFS_ADDR_CTRL, d, g);
        check("discovery address silent", 1'b0, g);
        check("discovery not selected", s, sel_count);
        u_host.wr(ADDR_BCAST, OFS_CB_CTRL, 8'h15, 1'b1);
        check("broadcast selected", s + 1, sel_count);
        rd_chk("broadcast write", OFS_CB_CTRL, 8'h15);
        u_host.rd(ADDR_BCAST, OFS_CB_CTRL, d, g);
        check("broadcast read silent", 1'b0, g);
        s = sel_count;
        u_host.wr(6'h06, OFS_CB_CTRL, 8'h2a, 1'b1);
        check("foreign not selected", s, sel_count);
        rd_chk("foreign write", OFS_CB_CTRL, 8'h15);
        rd_chk("neighbour register", OFS_CB_TIME, 8'h00);
        rd_chk("reserved register", 8'h13, 8'h00);
    endtask : t_range

    task automatic t_protect();
        u_host.wr(NA, OFS_PROT_BASE, 8'h12, 1'b1);
        check("locked write", BLANK[7:0], prot_config[7:0]);
        u_host.wr(NA, OFS_GATE, GATE_UNLOCK, 1'b1);
        u_host.wr(NA, OFS_PROT_BASE, 8'h12, 1'b1);
        check("unlocked write", 8'h12, prot_config[7:0]);
        u_host.wr(NA, OFS_GATE, GATE_UNLOCK, 1'b1);
        u_host.wr(NA, OFS_CB_TIME, 8'h00, 1'b1);
        u_host.wr(NA, OFS_PROT_BASE + 8'h01, 8'h34, 1'b1);
        check("cancelled unlock", BLANK[15:8], prot_config[15:8]);
        rd_chk("protected readback", OFS_PROT_BASE, 8'h12);
        u_host.wr(NA, OFS_GATE, GATE_RELOAD, 1'b1);
        check("reload", BLANK, prot_config);
    endtask : t_protect

    task automatic t_crc_and_reset();
        u_host.wr(NA, OFS_IO_CTRL, 8'h01, 1'b1);
        u_host.wr(NA, OFS_CB_CTRL, 8'h3f, 1'b0);
        rd_chk("bad check byte", OFS_CB_CTRL, 8'h15);
        u_host.rd(NA, OFS_FAULT_ST, d, g);
        check("check fault flag", 1'b1, d[CRC_BIT]);
        check("south alert on fault", 1'b1, alert_south_out);
        u_host.wr(NA, OFS_RESET, RESET_CODE, 1'b1);
        repeat (2) @(negedge core_clk);
        check("soft reset address", 6'h00, node_address);
        check("soft reset alert", 1'b1, alert_south_out);
        u_host.wr(ADDR_NONE, OFS_ADDR_CTRL, NA, 1'b1);
        rd_chk("control reinit", OFS_CB_CTRL, 8'h00);
        rd_chk("fault status reinit", OFS_FAULT_ST, FAULT_ST_RST);
    endtask : t_crc_and_reset

    task automatic burn(input logic [7:0] v);
        u_host.wr(NA, OFS_GATE, GATE_UNLOCK, 1'b1);
        u_host.wr(NA, OFS_PROT_BASE, v, 1'b1);
        u_host.wr(NA, OFS_BURN, BURN_CODE, 1'b1);
    endtask : burn

    task automatic t_burn();
        int n;
        programming_supply_pins = 1'b1;
        burn(8'h77);
        for (n = 0; n < 16 && otp_burned !== 1'b1; n++) @(negedge core_clk);
        check("burned", 1'b1, otp_burned);
        burn(8'h88);
        programming_supply_pins = 1'b0;
        u_host.wr(NA, OFS_GATE, GATE_RELOAD, 1'b1);
        check("one-time image", {BLANK[95:8], 8'h77}, prot_config);
    endtask : t_burn

    task automatic stop_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        failures = 0;
        compares = 0;
        reset = 1'b1;
        alert_north_in = 1'b0;
        programming_supply_pins = 1'b0;
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        t_reset();
        t_address();
        t_range();
        t_protect();
        t_crc_and_reset();
        t_burn();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        stop_test();
    end
endmodule : testbench

// ==== design/snar_pkg.sv ====
// Package for the stacked node addressing register bank.
// Assumes one core clock domain; all link pins are sampled into it.
package snar_pkg;
    localparam int          NODE_AW        = 6;
    localparam int          REG_W          = 8;
    localparam int          REG_AW         = 8;
    localparam int          PROT_N         = 12;
    localparam logic [5:0]  ADDR_NONE      = 6'h00;
    localparam logic [5:0]  ADDR_MIN       = 6'h01;
    localparam logic [5:0]  ADDR_MAX       = 6'h3e;
    localparam logic [5:0]  ADDR_BCAST     = 6'h3f;
    localparam logic [7:0]  GATE_UNLOCK    = 8'h35;
    localparam logic [7:0]  GATE_RELOAD    = 8'h27;
    localparam logic [7:0]  BURN_CODE      = 8'h91;
    localparam logic [7:0]  RESET_CODE     = 8'ha5;
    localparam logic [7:0]  OFS_DEV_STATUS = 8'h00;
    localparam logic [7:0]  OFS_ALERT_ST   = 8'h20;
    localparam logic [7:0]  OFS_FAULT_ST   = 8'h21;
    localparam logic [7:0]  OFS_ADC_CTRL   = 8'h30;
    localparam logic [7:0]  OFS_IO_CTRL    = 8'h31;
    localparam logic [7:0]  OFS_CB_CTRL    = 8'h32;
    localparam logic [7:0]  OFS_CB_TIME    = 8'h33;
    localparam logic [7:0]  OFS_ADC_CONV   = 8'h34;
    localparam logic [7:0]  OFS_GATE       = 8'h3a;
    localparam logic [7:0]  OFS_ADDR_CTRL  = 8'h3b;
    localparam logic [7:0]  OFS_RESET      = 8'h3c;
    localparam logic [7:0]  OFS_TEST_SEL   = 8'h3d;
    localparam logic [7:0]  OFS_BURN       = 8'h3f;
    localparam logic [7:0]  OFS_PROT_BASE  = 8'h40;
    localparam logic [7:0]  OFS_PROT_LAST  = 8'h4b;
    localparam logic [7:0]  OFS_PROT_WLAST = 8'h47;
    localparam logic [7:0]  ALERT_ST_RST   = 8'h80;
    localparam logic [7:0]  FAULT_ST_RST   = 8'h08;
    localparam int          AR_BIT         = 7;
    localparam int          PARITY_BIT     = 6;
    localparam int          CRC_BIT        = 0;
    localparam int          CRC_EN_BIT     = 0;
    localparam int          WR_BIT         = 0;
endpackage : snar_pkg

// ==== design/snar_prot_mem.sv ====
// Protected register store: one data byte plus an even parity bit per entry.
// Assumes one write or one bulk load per cycle; read data come out of a register.
`timescale 1ns/100ps
module snar_prot_mem
    import snar_pkg::*;
#(
    parameter int N = PROT_N
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              load_all,
    input  wire logic [N*8-1:0]    load_data,
    input  wire logic              wr_en,
    input  wire logic [3:0]        wr_idx,
    input  wire logic [7:0]        wr_data,
    input  wire logic [3:0]        rd_idx,
    output logic      [7:0]        rd_data,
    output logic      [N*8-1:0]    all_data,
    output logic                   parity_bad
);
    logic [7:0]   mem_q [N];
    logic         par_q [N];
    logic [N-1:0] bad;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ent
            // Parity is recomputed on every update, so only later corruption trips it.
            always_ff @(posedge core_clk) begin
                if (reset || load_all) begin
                    mem_q[g] <= load_data[g*8 +: 8];
                    par_q[g] <= ^load_data[g*8 +: 8];
                end else if (wr_en && wr_idx == 4'(g)) begin
                    mem_q[g] <= wr_data;
                    par_q[g] <= ^wr_data;
                end
            end
            assign bad[g]            = (^mem_q[g]) != par_q[g];
            assign all_data[g*8 +: 8] = mem_q[g];
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data    <= 8'h00;
            parity_bad <= 1'b0;
        end else begin
            rd_data    <= (rd_idx < 4'(N)) ? mem_q[rd_idx] : 8'h00;
            parity_bad <= |bad;
        end
    end
endmodule : snar_prot_mem

// ==== design/snar_regs.sv ====
// Node addressing and register bank of one stacked monitor node.
// Assumes a packet decoder on core_clk presents complete frames as
// wr_stb / rd_stb strobes; chip selects and alerts are raw pins.
`timescale 1ns/100ps
module snar_regs
    import snar_pkg::*;
#(
    parameter logic [PROT_N*8-1:0] OTP_BLANK = '0
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 cs_in,
    input  wire logic                 alert_north_in,
    input  wire logic                 programming_supply_pins,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    input  wire logic [7:0]           pkt_hdr,
    input  wire logic [7:0]           pkt_reg,
    input  wire logic [7:0]           pkt_data,
    input  wire logic                 pkt_crc_ok,
    output logic                      cs_north_out,
    output logic                      alert_south_out,
    output logic                      selected,
    output logic                      rd_valid,
    output logic      [7:0]           rd_data,
    output logic      [NODE_AW-1:0]   node_address,
    output logic                      otp_burned,
    output logic      [PROT_N*8-1:0]  prot_config
);
    logic [2:0] pin_s;
    logic       cs_s;
    logic       alert_n_s;
    logic       supply_s;
    logic       address_request_flag_q;
    logic       unlock_q;
    logic       crc_fault_q;
    logic       parity_q;
    logic       soft_reset_q;
    logic       reload_q;
    logic [PROT_N*8-1:0] otp_q;
    logic [7:0] adc_ctrl_q, io_ctrl_q, cb_ctrl_q, cb_time_q, adc_conv_q, test_q, gate_q;
    logic       any_reset;
    logic       addr_valid;
    logic       for_me;
    logic       wr_ok;
    logic       prot_range;
    logic       prot_wr;
    logic [7:0] prot_rd;
    logic       parity_bad;
    logic       rd_pend_q;
    logic [7:0] rd_reg_q;
    logic [7:0] rd_mux;
    logic [NODE_AW-1:0] hdr_addr;

    snar_sync #(.W(3)) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in ({programming_supply_pins, cs_in, alert_north_in}),
        .sync_out (pin_s)
    );
    assign supply_s  = pin_s[2];
    assign cs_s      = pin_s[1];
    assign alert_n_s = pin_s[0];

    // The reset command acts one cycle after its write, like a power-on reset.
    assign any_reset  = reset || soft_reset_q;
    assign addr_valid = node_address >= ADDR_MIN && node_address <= ADDR_MAX;
    assign hdr_addr   = pkt_hdr[NODE_AW:1];
    // Discovery traffic at zero only reaches the lowest unaddressed node.
    assign for_me = cs_s && ((hdr_addr == node_address) ||
                    (hdr_addr == ADDR_BCAST && addr_valid));
    assign wr_ok  = wr_stb && for_me && pkt_hdr[WR_BIT] &&
                    (!io_ctrl_q[CRC_EN_BIT] || pkt_crc_ok);
    assign prot_range = pkt_reg >= OFS_PROT_BASE && pkt_reg <= OFS_PROT_WLAST;
    assign prot_wr    = wr_ok && prot_range && unlock_q;

    snar_prot_mem #(.N(PROT_N)) u_prot (
        .core_clk   (core_clk),
        .reset      (any_reset),
        .load_all   (reload_q),
        .load_data  (otp_q),
        .wr_en      (prot_wr),
        .wr_idx     (4'(pkt_reg - OFS_PROT_BASE)),
        .wr_data    (pkt_data),
        .rd_idx     (4'(pkt_reg - OFS_PROT_BASE)),
        .rd_data    (prot_rd),
        .all_data   (prot_config),
        .parity_bad (parity_bad)
    );

    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            node_address           <= ADDR_NONE;
            address_request_flag_q <= 1'b0;
        end else if (wr_ok && pkt_reg == OFS_ADDR_CTRL) begin
            node_address           <= pkt_data[NODE_AW-1:0];
            address_request_flag_q <= 1'b1;
        end
    end

    // South alert rises on reset and drops once addressed, unless north still alerts or a check-byte or parity fault is flagged.
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            alert_south_out <= 1'b1;
        end else begin
            alert_south_out <= !address_request_flag_q || alert_n_s || crc_fault_q || parity_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            cs_north_out <= 1'b0;
        end else begin
            cs_north_out <= addr_valid && address_request_flag_q && cs_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            unlock_q <= 1'b0;
        end else if (wr_ok) begin
            unlock_q <= (pkt_reg == OFS_GATE) && (pkt_data == GATE_UNLOCK);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reload_q     <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            reload_q     <= wr_ok && pkt_reg == OFS_GATE && pkt_data == GATE_RELOAD;
            soft_reset_q <= wr_ok && pkt_reg == OFS_RESET && pkt_data == RESET_CODE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            adc_ctrl_q <= 8'h00;
            io_ctrl_q  <= 8'h00;
            cb_ctrl_q  <= 8'h00;
            cb_time_q  <= 8'h00;
            adc_conv_q <= 8'h00;
            test_q     <= 8'h00;
            gate_q     <= 8'h00;
        end else if (wr_ok) begin
            unique case (pkt_reg)
                OFS_ADC_CTRL: adc_ctrl_q <= pkt_data;
                OFS_IO_CTRL:  io_ctrl_q  <= pkt_data;
                OFS_CB_CTRL:  cb_ctrl_q  <= pkt_data;
                OFS_CB_TIME:  cb_time_q  <= pkt_data;
                OFS_ADC_CONV: adc_conv_q <= pkt_data;
                OFS_TEST_SEL: test_q     <= pkt_data;
                OFS_GATE:     gate_q     <= pkt_data;
                default: begin
                end
            endcase
        end
    end

    // Hardware set wins over a host clear in the same cycle.
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            crc_fault_q <= 1'b0;
            parity_q    <= 1'b0;
        end else begin
            crc_fault_q <= (wr_stb && for_me && io_ctrl_q[CRC_EN_BIT] && !pkt_crc_ok) ||
                           (crc_fault_q && !(wr_ok && pkt_reg == OFS_FAULT_ST && pkt_data[CRC_BIT]));
            parity_q    <= parity_bad ||
                           (parity_q && !(wr_ok && pkt_reg == OFS_ALERT_ST && pkt_data[PARITY_BIT]));
        end
    end

    // One-time programming: survives soft resets, only a power-on reset clears it.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            otp_q      <= OTP_BLANK;
            otp_burned <= 1'b0;
        end else if (wr_ok && pkt_reg == OFS_BURN && pkt_data == BURN_CODE &&
                     supply_s && !otp_burned) begin
            otp_q      <= prot_config;
            otp_burned <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        unique case (rd_reg_q)
            OFS_DEV_STATUS: rd_mux = {address_request_flag_q, 7'h00};
            OFS_ALERT_ST:   rd_mux = {ALERT_ST_RST[7], parity_q, 6'h00};
            OFS_FAULT_ST:   rd_mux = {4'h0, FAULT_ST_RST[3], 2'h0, crc_fault_q};
            OFS_ADC_CTRL:   rd_mux = adc_ctrl_q;
            OFS_IO_CTRL:    rd_mux = io_ctrl_q;
            OFS_CB_CTRL:    rd_mux = cb_ctrl_q;
            OFS_CB_TIME:    rd_mux = cb_time_q;
            OFS_ADC_CONV:   rd_mux = adc_conv_q;
            OFS_GATE:       rd_mux = gate_q;
            OFS_ADDR_CTRL:  rd_mux = {address_request_flag_q, 1'b0, node_address};
            OFS_TEST_SEL:   rd_mux = test_q;
            OFS_BURN:       rd_mux = {7'h00, otp_burned};
            default: begin
                if (rd_reg_q >= OFS_PROT_BASE && rd_reg_q <= OFS_PROT_LAST) begin
                    rd_mux = prot_rd;
                end
            end
        endcase
    end

    // Reads take two cycles so the protected store's registered output is ready.
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            rd_pend_q <= 1'b0;
            rd_reg_q  <= 8'h00;
            rd_valid  <= 1'b0;
            rd_data   <= 8'h00;
            selected  <= 1'b0;
        end else begin
            rd_pend_q <= rd_stb && for_me && hdr_addr != ADDR_BCAST;
            if (rd_stb) begin
                rd_reg_q <= pkt_reg;
            end
            rd_valid  <= rd_pend_q;
            rd_data   <= rd_pend_q ? rd_mux : 8'h00;
            selected  <= for_me && (wr_stb || rd_stb);
        end
    end

    // Named steps shared by the properties below.
    sequence seq_addr_wr;
        wr_ok && pkt_reg == OFS_ADDR_CTRL;
    endsequence

    sequence seq_unlock_wr;
        wr_ok && pkt_reg == OFS_GATE && pkt_data == GATE_UNLOCK;
    endsequence

    sequence seq_reload_wr;
        wr_ok && pkt_reg == OFS_GATE && pkt_data == GATE_RELOAD;
    endsequence

    sequence seq_bad_crc;
        wr_stb && for_me && io_ctrl_q[CRC_EN_BIT] && !pkt_crc_ok;
    endsequence

    sequence seq_rd_req;
        rd_stb && for_me && hdr_addr != ADDR_BCAST;
    endsequence

    sequence seq_rd_answer;
        rd_pend_q ##1 rd_valid;
    endsequence

    AST_CS_BLOCK: assert property (@(posedge core_clk) disable iff (reset)
        node_address == ADDR_NONE |=> !cs_north_out)
        else $error("north select passed with no address");
    AST_CS_FOLLOW: assert property (@(posedge core_clk) disable iff (any_reset)
        (addr_valid && address_request_flag_q && cs_s) |=> cs_north_out)
        else $error("north select did not follow");
    AST_RESET_STATE: assert property (@(posedge core_clk) disable iff (reset)
        soft_reset_q |=> node_address == ADDR_NONE && !address_request_flag_q && alert_south_out)
        else $error("reset state wrong");
    AST_ADDR_WRITE: assert property (@(posedge core_clk) disable iff (any_reset)
        seq_addr_wr |=> address_request_flag_q && node_address == $past(pkt_data[NODE_AW-1:0]))
        else $error("address write not taken");
    AST_BAD_CRC: assert property (@(posedge core_clk) disable iff (any_reset)
        seq_bad_crc |=> crc_fault_q && $stable(io_ctrl_q))
        else $error("bad check byte not handled");
    AST_UNLOCK_ONE: assert property (@(posedge core_clk) disable iff (any_reset)
        (wr_ok && !(pkt_reg == OFS_GATE && pkt_data == GATE_UNLOCK)) |=> !unlock_q)
        else $error("unlock not cancelled");
    AST_UNLOCK_CLR: assert property (@(posedge core_clk) disable iff (reset)
        soft_reset_q |=> !unlock_q)
        else $error("unlock survived reset");
    AST_BURN_ONCE: assert property (@(posedge core_clk) disable iff (reset)
        otp_burned |=> otp_burned && $stable(otp_q))
        else $error("otp changed after burn");
    AST_BCAST: assert property (@(posedge core_clk) disable iff (any_reset)
        (cs_s && hdr_addr == ADDR_BCAST && !addr_valid) |-> !for_me)
        else $error("broadcast taken without address");
    AST_PARITY: assert property (@(posedge core_clk) disable iff (any_reset)
        parity_bad |=> parity_q)
        else $error("parity flag not set");

    AST_CS_RESET: assert property (@(posedge core_clk)
        any_reset |=> !cs_north_out && alert_south_out)
        else $error("pins wrong after reset");
    AST_ALERT_CLEAR: assert property (@(posedge core_clk) disable iff (any_reset)
        (address_request_flag_q && !alert_n_s && !crc_fault_q && !parity_q) |=> !alert_south_out)
        else $error("south alert stuck after address");
    AST_ALERT_PASS: assert property (@(posedge core_clk) disable iff (any_reset)
        alert_n_s |=> alert_south_out)
        else $error("north alert not passed south");

    AST_SELECT: assert property (@(posedge core_clk) disable iff (any_reset)
        (for_me && (wr_stb || rd_stb)) |=> selected)
        else $error("select pulse missing");
    AST_RD_ANSWER: assert property (@(posedge core_clk) disable iff (any_reset)
        seq_rd_req |=> seq_rd_answer)
        else $error("read not answered");
    AST_RD_BCAST: assert property (@(posedge core_clk) disable iff (any_reset)
        (rd_stb && hdr_addr == ADDR_BCAST) |=> !rd_pend_q)
        else $error("broadcast read answered");
    AST_RD_ZERO: assert property (@(posedge core_clk) disable iff (any_reset)
        (rd_pend_q && (rd_reg_q > OFS_PROT_LAST || (rd_reg_q > OFS_DEV_STATUS && rd_reg_q < OFS_ALERT_ST)))
            |=> rd_valid && rd_data == 8'h00)
        else $error("reserved register not zero");

    AST_UNLOCK_ARM: assert property (@(posedge core_clk) disable iff (any_reset)
        seq_unlock_wr |=> unlock_q)
        else $error("unlock not armed");
    AST_PROT_LOCKED: assert property (@(posedge core_clk) disable iff (any_reset)
        (wr_ok && prot_range && !unlock_q && !reload_q) |=> $stable(prot_config))
        else $error("locked protected write taken");
    AST_RELOAD: assert property (@(posedge core_clk) disable iff (any_reset)
        seq_reload_wr |=> reload_q ##1 prot_config == $past(otp_q))
        else $error("reload did not restore defaults");
    AST_BURN_SUPPLY: assert property (@(posedge core_clk) disable iff (reset)
        $rose(otp_burned) |-> $past(supply_s))
        else $error("burn without programming supply");
endmodule : snar_regs

// ==== design/snar_sync.sv ====
// Two flip-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes the inputs are slow against core_clk.
`timescale 1ns/100ps
module snar_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : snar_sync
